//--- core/pll_ctl.sv
// Programming port, dividers, phase detector and lock detect of the synthesizer.
//
// The implementer's own choices: the plain strobed port and the address map.
`timescale 1ns/10ps
// ****************************************************************
// Summary of operation
// - Each rising serial clock edge shifts one bit into the 20-bit primary register, or the 8-bit auxiliary one when the select is high.
// - Bits enter the primary register only while the transfer strobe is low.
// - A rising edge of the transfer strobe copies the whole primary register into the secondary register at once.
// - Interface select high means direct pin programming, low means serial programming on the shared pins.
// - In direct mode the reference, main and swallow counter values come straight from their pins.
// - The active-low prescaler enable (bit 19 of the loaded word in serial mode), when high, feeds the oscillator input straight to the main counter.
// - Modulus choice high selects 5/6, low selects 10/11.
// - In serial mode the monitor output carries either the modulus control or the raw prescaler output, per the auxiliary bits.
// - The lock pin is open drain, released while locked and pulled low otherwise.
// - The down pulse goes low when the main signal leads, the up pulse when the reference leads.
// - The auxiliary bits act only while the auxiliary gate input is low.
// - Every digital input reads as low when left undriven.
// - The reference and main counters divide by integer values from the loaded word, or from the pins in direct mode.
// ****************************************************************
module pll_ctl #(
	parameter int                   LOCK_WIN_W     = pll_ctl_pkg::LOCK_WIN_W,
	parameter logic [LOCK_WIN_W-1:0] LOCK_WIN_RESET = pll_ctl_pkg::LOCK_WINDOW_RST
) (
	input  wire logic                              core_clk,
	input  wire logic                              nrst,
	input  wire logic [pll_ctl_pkg::ADDR_W-1:0]    reg_addr,
	input  wire logic [pll_ctl_pkg::DATA_W-1:0]    reg_wdata,
	input  wire logic                              reg_wr,
	input  wire logic                              reg_rd,
	output logic      [pll_ctl_pkg::DATA_W-1:0]    reg_rdata,
	output logic                                   irq,
	input  wire logic [pll_ctl_pkg::R_W-1:0]       direct_r_pins,
	input  wire logic [pll_ctl_pkg::M_W-1:0]       direct_m_pins,
	input  wire logic [pll_ctl_pkg::A_W-1:0]       direct_a_pins,
	input  wire logic                              interface_select,
	input  wire logic                              prescaler_enable_n,
	input  wire logic                              modulus_choice,
	input  wire logic                              aux_bits_gate,
	input  wire logic                              ref_in,
	input  wire logic                              osc_in,
	output logic                                   modulus_control_signal,
	output logic                                   monitor_output,
	output logic                                   pump_down_pulse,
	output logic                                   pump_up_pulse,
	output logic                                   detector_nand_node,
	input  wire logic                              lock_indicator_i,
	output logic                                   lock_indicator_o,
	output logic                                   lock_indicator_oe
);

	// ****************************************************************
	// Elaboration checks
	// ****************************************************************
	generate
		if (LOCK_WIN_W < 1 || LOCK_WIN_W > pll_ctl_pkg::DATA_W) begin : g_bad_win
			$error("pll_ctl: LOCK_WIN_W must lie between 1 and the data width.");
		end
	endgenerate

	// ****************************************************************
	// Pin synchronisers
	// ****************************************************************
	// Pull-downs make floating pins low, so reset puts the synchronisers at zero as well.
	pll_ctl_pkg::pin_bundle_t pins_raw;
	pll_ctl_pkg::pin_bundle_t pins_meta_q;
	pll_ctl_pkg::pin_bundle_t pins_q;
	pll_ctl_pkg::pin_bundle_t pins_prev_q;
	logic [2:0]               live_q;

	always_comb begin
		pins_raw.ref_in   = ref_in;
		pins_raw.osc_in   = osc_in;
		pins_raw.lock_pin = lock_indicator_i;
		pins_raw.aux_gate = aux_bits_gate;
		pins_raw.mod_sel  = modulus_choice;
		pins_raw.psc_en_n = prescaler_enable_n;
		pins_raw.direct   = interface_select;
		pins_raw.a        = direct_a_pins;
		pins_raw.m        = direct_m_pins;
		pins_raw.r        = direct_r_pins;
	end

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			pins_meta_q <= '0;
			pins_q      <= '0;
			pins_prev_q <= '0;
			live_q      <= '0;
		end else begin
			pins_meta_q <= pins_raw;
			pins_q      <= pins_meta_q;
			pins_prev_q <= pins_q;
			live_q      <= {live_q[1:0], 1'b1};
		end
	end

	// Shared pins: in serial mode these direct pins carry the serial port.
	logic serial_mode;
	logic serial_shift_clock;
	logic serial_input_bits;
	logic transfer_strobe;
	logic aux_shift_select;
	logic sclk_rise;
	logic strobe_rise;
	logic osc_rise;
	logic ref_rise;

	assign serial_mode        = !pins_q.direct;
	assign serial_shift_clock = pins_q.m[6];
	assign serial_input_bits  = pins_q.m[5];
	assign transfer_strobe    = pins_q.m[4];
	assign aux_shift_select   = pins_q.a[1];
	// Edges count only once both samples hold real pin levels; otherwise the idle-high
	// strobe would look like a rising edge right after reset and fire a false transfer.
	assign sclk_rise   = live_q[2] && serial_mode && serial_shift_clock && !pins_prev_q.m[6];
	assign strobe_rise = live_q[2] && serial_mode && transfer_strobe && !pins_prev_q.m[4];
	assign osc_rise    = live_q[2] && pins_q.osc_in && !pins_prev_q.osc_in;
	assign ref_rise    = live_q[2] && pins_q.ref_in && !pins_prev_q.ref_in;

	// ****************************************************************
	// Serial loading
	// ****************************************************************
	logic [pll_ctl_pkg::PRIMARY_W-1:0] primary_q;
	logic [pll_ctl_pkg::PRIMARY_W-1:0] secondary_q;
	logic [pll_ctl_pkg::AUX_W-1:0]     aux_q;
	logic                              ev_aux;

	assign ev_aux = sclk_rise && aux_shift_select;

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			primary_q <= '0;
		end else if (sclk_rise && !aux_shift_select && !transfer_strobe) begin
			primary_q <= {primary_q[pll_ctl_pkg::PRIMARY_W-2:0], serial_input_bits};
		end
	end

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			aux_q <= '0;
		end else if (ev_aux) begin
			aux_q <= {aux_q[pll_ctl_pkg::AUX_W-2:0], serial_input_bits};
		end
	end

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			secondary_q <= '0;
		end else if (strobe_rise) begin
			secondary_q <= primary_q;
		end
	end

	// ****************************************************************
	// Active divider settings
	// ****************************************************************
	pll_ctl_pkg::counter_set_t active;
	logic                      bypass;
	logic [pll_ctl_pkg::AUX_W-1:0] aux_eff;

	always_comb begin
		if (serial_mode) begin
			active.r = secondary_q[pll_ctl_pkg::R_LSB +: pll_ctl_pkg::R_W];
			active.m = secondary_q[pll_ctl_pkg::M_LSB +: pll_ctl_pkg::M_W];
			active.a = secondary_q[pll_ctl_pkg::A_LSB +: pll_ctl_pkg::A_W];
			bypass   = secondary_q[pll_ctl_pkg::BYPASS_BIT];
		end else begin
			active.r = pins_q.r;
			active.m = pins_q.m;
			active.a = pins_q.a;
			bypass   = pins_q.psc_en_n;
		end
	end

	assign aux_eff = pins_q.aux_gate ? '0 : aux_q;

	// ****************************************************************
	// Prescaler, main and swallow counters
	// ****************************************************************
	logic [pll_ctl_pkg::PSC_W-1:0] psc_base;
	logic [pll_ctl_pkg::PSC_W-1:0] psc_mod;
	logic [pll_ctl_pkg::PSC_W-1:0] psc_cnt_q;
	logic                          psc_tick;
	logic                          psc_out_q;
	logic [pll_ctl_pkg::M_W-1:0]   main_cnt_q;
	logic [pll_ctl_pkg::A_W-1:0]   swallow_q;
	logic                          main_tick;
	logic                          mod_ctl_q;

	assign psc_base  = pins_q.mod_sel ? pll_ctl_pkg::PSC_SMALL : pll_ctl_pkg::PSC_LARGE;
	assign psc_mod   = (swallow_q != '0) ? psc_base + pll_ctl_pkg::PSC_ONE : psc_base;
	assign psc_tick  = osc_rise && (bypass || (psc_cnt_q == psc_mod - pll_ctl_pkg::PSC_ONE));
	assign main_tick = psc_tick && (main_cnt_q <= 1);

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			psc_cnt_q <= '0;
		end else if (bypass || psc_tick) begin
			psc_cnt_q <= '0;
		end else if (osc_rise) begin
			psc_cnt_q <= psc_cnt_q + pll_ctl_pkg::PSC_ONE;
		end
	end

	// The raw prescaler output is shown as a toggle, one edge per prescaler cycle.
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			psc_out_q <= 1'b0;
		end else if (psc_tick) begin
			psc_out_q <= !psc_out_q;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			main_cnt_q <= '0;
			swallow_q  <= '0;
		end else if (main_tick) begin
			main_cnt_q <= active.m;
			swallow_q  <= bypass ? '0 : active.a;
		end else if (psc_tick) begin
			main_cnt_q <= main_cnt_q - 1'b1;
			if (swallow_q != '0) begin
				swallow_q <= swallow_q - 1'b1;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			mod_ctl_q <= 1'b0;
		end else begin
			mod_ctl_q <= (swallow_q != '0);
		end
	end

	assign modulus_control_signal = mod_ctl_q;

	// ****************************************************************
	// Reference counter
	// ****************************************************************
	logic [pll_ctl_pkg::R_W-1:0] ref_cnt_q;
	logic [pll_ctl_pkg::R_W:0]   ref_next;
	logic                        ref_tick;

	assign ref_next = {1'b0, ref_cnt_q} + 1'b1;
	assign ref_tick = ref_rise && (ref_next >= {1'b0, active.r});

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			ref_cnt_q <= '0;
		end else if (ref_tick) begin
			ref_cnt_q <= '0;
		end else if (ref_rise) begin
			ref_cnt_q <= ref_next[pll_ctl_pkg::R_W-1:0];
		end
	end

	// ****************************************************************
	// Phase detector
	// ****************************************************************
	// Active-low flags are held directly so the pump pins come straight from flops.
	logic up_n_q;
	logic dn_n_q;

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			up_n_q <= 1'b1;
			dn_n_q <= 1'b1;
		end else if (!up_n_q && !dn_n_q) begin
			up_n_q <= 1'b1;
			dn_n_q <= 1'b1;
		end else begin
			if (ref_tick) begin
				up_n_q <= 1'b0;
			end
			if (main_tick) begin
				dn_n_q <= 1'b0;
			end
		end
	end

	assign pump_up_pulse      = up_n_q;
	assign pump_down_pulse    = dn_n_q;
	assign detector_nand_node = !(dn_n_q && up_n_q);

	// ****************************************************************
	// Lock detect
	// ****************************************************************
	// A streak counter stands in for the external filter capacitor: the lock state
	// flips only after the node disagrees with it for a whole window.
	logic [LOCK_WIN_W-1:0] window_q;
	logic [LOCK_WIN_W-1:0] streak_q;
	logic                  lock_q;
	logic                  disagree;
	logic                  lock_flip;

	assign disagree  = lock_q ? detector_nand_node : !detector_nand_node;
	assign lock_flip = disagree && ((streak_q + 1'b1) >= window_q);

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			streak_q <= '0;
		end else if (!disagree || lock_flip) begin
			streak_q <= '0;
		end else begin
			streak_q <= streak_q + 1'b1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			lock_q <= 1'b0;
		end else if (lock_flip) begin
			lock_q <= !lock_q;
		end
	end

	assign lock_indicator_o  = 1'b0;
	assign lock_indicator_oe = !lock_q;

	// ****************************************************************
	// Monitor output
	// ****************************************************************
	logic mon_q;

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			mon_q <= 1'b0;
		end else if (!serial_mode) begin
			mon_q <= 1'b0;
		end else if (aux_eff[pll_ctl_pkg::MON_SEL_BIT]) begin
			mon_q <= psc_out_q;
		end else begin
			mon_q <= mod_ctl_q;
		end
	end

	assign monitor_output = mon_q;

	// ****************************************************************
	// Registers and interrupt
	// ****************************************************************
	logic [pll_ctl_pkg::EV_W-1:0] status_q;
	logic [pll_ctl_pkg::EV_W-1:0] mask_q;
	logic [pll_ctl_pkg::EV_W-1:0] events;
	logic [pll_ctl_pkg::EV_W-1:0] clear_bits;
	logic [pll_ctl_pkg::DATA_W-1:0] rdata_d;
	logic [pll_ctl_pkg::DATA_W-1:0] rdata_q;

	always_comb begin
		events = '0;
		events[pll_ctl_pkg::EV_LOCK_GAIN] = lock_flip && !lock_q;
		events[pll_ctl_pkg::EV_LOCK_LOSS] = lock_flip && lock_q;
		events[pll_ctl_pkg::EV_TRANSFER]  = strobe_rise;
		events[pll_ctl_pkg::EV_AUX_SHIFT] = ev_aux;
	end

	assign clear_bits = (reg_wr && reg_addr == pll_ctl_pkg::OFF_STATUS) ?
		reg_wdata[pll_ctl_pkg::EV_W-1:0] : pll_ctl_pkg::EV_ZERO;

	// A new event beats a clear written in the same cycle.
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			status_q <= pll_ctl_pkg::EV_ZERO;
		end else begin
			status_q <= (status_q & ~clear_bits) | events;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			mask_q   <= pll_ctl_pkg::EV_ZERO;
			window_q <= LOCK_WIN_RESET;
		end else if (reg_wr) begin
			if (reg_addr == pll_ctl_pkg::OFF_MASK) begin
				mask_q <= reg_wdata[pll_ctl_pkg::EV_W-1:0];
			end
			if (reg_addr == pll_ctl_pkg::OFF_WINDOW) begin
				window_q <= reg_wdata[LOCK_WIN_W-1:0];
			end
		end
	end

	always_comb begin
		rdata_d = pll_ctl_pkg::DATA_ZERO;
		unique case (reg_addr)
			pll_ctl_pkg::OFF_STATUS:    rdata_d[pll_ctl_pkg::EV_W-1:0] = status_q;
			pll_ctl_pkg::OFF_MASK:      rdata_d[pll_ctl_pkg::EV_W-1:0] = mask_q;
			pll_ctl_pkg::OFF_WINDOW:    rdata_d[LOCK_WIN_W-1:0] = window_q;
			pll_ctl_pkg::OFF_SECONDARY: rdata_d[pll_ctl_pkg::PRIMARY_W-1:0] = secondary_q;
			pll_ctl_pkg::OFF_AUX:       rdata_d[pll_ctl_pkg::AUX_W-1:0] = aux_q;
			pll_ctl_pkg::OFF_ACTIVE:    rdata_d[$bits(active)-1:0] = active;
			pll_ctl_pkg::OFF_STATE: begin
				rdata_d[pll_ctl_pkg::ST_DIRECT]    = pins_q.direct;
				rdata_d[pll_ctl_pkg::ST_LOCKED]    = lock_q;
				rdata_d[pll_ctl_pkg::ST_BYPASS]    = bypass;
				rdata_d[pll_ctl_pkg::ST_MOD_SMALL] = pins_q.mod_sel;
				rdata_d[pll_ctl_pkg::ST_AUX_GATE]  = pins_q.aux_gate;
				rdata_d[pll_ctl_pkg::ST_LOCK_PIN]  = pins_q.lock_pin;
			end
			default: rdata_d = pll_ctl_pkg::DATA_ZERO;
		endcase
	end

	// Read data stand only in the cycle after the read strobe.
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			rdata_q <= pll_ctl_pkg::DATA_ZERO;
		end else if (reg_rd) begin
			rdata_q <= rdata_d;
		end else begin
			rdata_q <= pll_ctl_pkg::DATA_ZERO;
		end
	end

	assign reg_rdata = rdata_q;
	assign irq       = |(status_q & mask_q);

endmodule : pll_ctl

//--- core/pll_ctl_pkg.sv
// Shared constants, register map and carrier types of the synthesizer control logic.
package pll_ctl_pkg;

	// ****************************************************************
	// Widths
	// ****************************************************************
	localparam int R_W       = 6;
	localparam int M_W       = 9;
	localparam int A_W       = 4;
	localparam int PRIMARY_W = 20;
	localparam int AUX_W     = 8;
	localparam int DATA_W    = 32;
	localparam int ADDR_W    = 4;
	localparam int EV_W      = 4;
	localparam int PSC_W     = 4;

	// ****************************************************************
	// Field positions inside the loaded serial word and the auxiliary bits
	// ****************************************************************
	localparam int A_LSB       = 0;
	localparam int M_LSB       = 4;
	localparam int R_LSB       = 13;
	localparam int BYPASS_BIT  = 19;
	localparam int MON_SEL_BIT = 0;

	// ****************************************************************
	// Prescaler moduli (base value, the swallow phase adds one)
	// ****************************************************************
	localparam logic [PSC_W-1:0] PSC_SMALL = 4'h5;
	localparam logic [PSC_W-1:0] PSC_LARGE = 4'ha;
	localparam logic [PSC_W-1:0] PSC_ONE   = 4'h1;

	// ****************************************************************
	// Register map (word index on the register port)
	// ****************************************************************
	localparam logic [ADDR_W-1:0] OFF_STATUS    = 4'h0;
	localparam logic [ADDR_W-1:0] OFF_MASK      = 4'h1;
	localparam logic [ADDR_W-1:0] OFF_WINDOW    = 4'h2;
	localparam logic [ADDR_W-1:0] OFF_SECONDARY = 4'h3;
	localparam logic [ADDR_W-1:0] OFF_AUX       = 4'h4;
	localparam logic [ADDR_W-1:0] OFF_ACTIVE    = 4'h5;
	localparam logic [ADDR_W-1:0] OFF_STATE     = 4'h6;

	// Status and mask bit positions.
	localparam int EV_LOCK_GAIN = 0;
	localparam int EV_LOCK_LOSS = 1;
	localparam int EV_TRANSFER  = 2;
	localparam int EV_AUX_SHIFT = 3;

	// State register bit positions.
	localparam int ST_DIRECT   = 0;
	localparam int ST_LOCKED   = 1;
	localparam int ST_BYPASS   = 2;
	localparam int ST_MOD_SMALL = 3;
	localparam int ST_AUX_GATE = 4;
	localparam int ST_LOCK_PIN = 5;

	// ****************************************************************
	// Reset values
	// ****************************************************************
	localparam logic [DATA_W-1:0] DATA_ZERO  = 32'h0000_0000;
	localparam logic [EV_W-1:0]   EV_ZERO    = 4'h0;
	localparam int                LOCK_WIN_W = 16;
	localparam logic [15:0]       LOCK_WINDOW_RST = 16'h0010;

	// ****************************************************************
	// Carrier types
	// ****************************************************************
	typedef struct packed {
		logic [R_W-1:0] r;
		logic [M_W-1:0] m;
		logic [A_W-1:0] a;
	} counter_set_t;

	typedef struct packed {
		logic           ref_in;
		logic           osc_in;
		logic           lock_pin;
		logic           aux_gate;
		logic           mod_sel;
		logic           psc_en_n;
		logic           direct;
		logic [A_W-1:0] a;
		logic [M_W-1:0] m;
		logic [R_W-1:0] r;
	} pin_bundle_t;

endpackage : pll_ctl_pkg

//--- bench/pll_ctl_chk.sv
// Port checker for the synthesizer control block.
`timescale 1ns/10ps
module pll_ctl_chk #(
	parameter int                    LOCK_WIN_W     = 16,
	parameter logic [LOCK_WIN_W-1:0] LOCK_WIN_RESET = 16'h0010
) (
	input wire logic                           core_clk,
	input wire logic                           nrst,
	input wire logic [pll_ctl_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [pll_ctl_pkg::DATA_W-1:0] reg_wdata,
	input wire logic                           reg_wr,
	input wire logic                           reg_rd,
	input wire logic [pll_ctl_pkg::DATA_W-1:0] reg_rdata,
	input wire logic                           irq,
	input wire logic                           interface_select,
	input wire logic                           monitor_output,
	input wire logic                           pump_down_pulse,
	input wire logic                           pump_up_pulse,
	input wire logic                           detector_nand_node,
	input wire logic                           lock_indicator_o,
	input wire logic                           lock_indicator_oe
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!nrst);
	property p_nand;
		detector_nand_node == !(pump_down_pulse && pump_up_pulse);
	endproperty
	a_nand: assert property (p_nand) else $error("nand node wrong");
	property p_lock_low;
		lock_indicator_o == 1'b0;
	endproperty
	a_lock_low: assert property (p_lock_low) else $error("lock pin drives high");
	property p_lock_gap;
		$changed(lock_indicator_oe) |=> $stable(lock_indicator_oe) [*2];
	endproperty
	a_lock_gap: assert property (p_lock_gap) else $error("lock state chatters");
	property p_pump_both;
		!pump_down_pulse && !pump_up_pulse |=> pump_down_pulse && pump_up_pulse;
	endproperty
	a_pump_both: assert property (p_pump_both) else $error("pumps not cleared together");
	property p_mon_direct;
		interface_select [*6] |-> !monitor_output;
	endproperty
	a_mon_direct: assert property (p_mon_direct) else $error("monitor active in direct mode");
	property p_rst;
		$rose(nrst) |-> pump_down_pulse && pump_up_pulse && lock_indicator_oe && !irq && !monitor_output;
	endproperty
	a_rst: assert property (p_rst) else $error("outputs not at reset values");
	property p_idle;
		!$past(reg_rd) |-> reg_rdata == pll_ctl_pkg::DATA_ZERO;
	endproperty
	a_idle: assert property (p_idle) else $error("read data outside read cycle");
	property p_unmap;
		reg_rd && reg_addr > pll_ctl_pkg::OFF_STATE |=> reg_rdata == pll_ctl_pkg::DATA_ZERO;
	endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
	property p_mask0;
		reg_wr && reg_addr == pll_ctl_pkg::OFF_MASK && reg_wdata == pll_ctl_pkg::DATA_ZERO |=> !irq;
	endproperty
	a_mask0: assert property (p_mask0) else $error("interrupt with all masked");
endmodule : pll_ctl_chk

bind pll_ctl pll_ctl_chk #(.LOCK_WIN_W(LOCK_WIN_W), .LOCK_WIN_RESET(LOCK_WIN_RESET)) u_pll_ctl_chk (
	.core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq), .interface_select(interface_select),
	.monitor_output(monitor_output), .pump_down_pulse(pump_down_pulse), .pump_up_pulse(pump_up_pulse),
	.detector_nand_node(detector_nand_node), .lock_indicator_o(lock_indicator_o),
	.lock_indicator_oe(lock_indicator_oe));

//--- bench/serial_host.sv
// Host controller model driving the shared programming pins.
`timescale 1ns/10ps
module serial_host (
	output logic [pll_ctl_pkg::R_W-1:0] r_pins,
	output logic [pll_ctl_pkg::M_W-1:0] m_pins,
	output logic [pll_ctl_pkg::A_W-1:0] a_pins,
	output logic                        select
);
	// ****************************************************************
	// Link timing: 125 ns serial clock, idle low between frames
	// ****************************************************************
	localparam realtime HALF = 62.5;
	initial begin
		select = 1'b0;
		r_pins = '0;
		m_pins = 9'h010;
		a_pins = '0;
	end
	task send(input logic [19:0] w, input logic aux, input logic lvl);
		int n;
		n = aux ? 8 : 20;
		a_pins[1] = aux;
		m_pins[4] = lvl;
		#HALF;
		for (int i = n - 1; i >= 0; i--) begin
			m_pins[5] = w[i];
			#HALF;
			m_pins[6] = 1'b1;
			#HALF;
			m_pins[6] = 1'b0;
		end
		// The data line is driven low after the frame rather than left floating.
		m_pins[5] = 1'b0;
		#HALF;
		a_pins[1] = 1'b0;
	endtask : send
	task strobe(input logic low_first);
		if (low_first) begin
			m_pins[4] = 1'b0;
			#HALF;
		end
		m_pins[4] = 1'b1;
		#HALF;
	endtask : strobe
	task direct(input logic [5:0] r, input logic [8:0] m, input logic [3:0] a);
		select = 1'b1;
		r_pins = r;
		m_pins = m;
		a_pins = a;
	endtask : direct
endmodule : serial_host

//--- bench/pll_ctl_tb.sv
// Self-checking bench for the synthesizer control block.
`timescale 1ns/10ps
module pll_ctl_tb;
	logic        core_clk, nrst, reg_wr, reg_rd, irq, sel, pe_n, mod_ch, gate, ref_in, osc_in;
	logic        mcs, mon, pd, pu, nand_n, lk_o, lk_oe, lk_i;
	logic [3:0]  reg_addr, a_p;
	logic [31:0] reg_wdata, reg_rdata;
	logic [5:0]  r_p;
	logic [8:0]  m_p;
	int          num_errors, cmp_count;
	localparam logic [19:0] W = 20'ha_5c31;
	// The lock pin is open drain with a board pull-up.
	assign lk_i = lk_oe ? lk_o : 1'b1;
	pll_ctl #(.LOCK_WIN_RESET(16'h0004)) u_pll_ctl (
		.core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq), .direct_r_pins(r_p), .direct_m_pins(m_p),
		.direct_a_pins(a_p), .interface_select(sel), .prescaler_enable_n(pe_n), .modulus_choice(mod_ch),
		.aux_bits_gate(gate), .ref_in(ref_in), .osc_in(osc_in), .modulus_control_signal(mcs),
		.monitor_output(mon), .pump_down_pulse(pd), .pump_up_pulse(pu), .detector_nand_node(nand_n),
		.lock_indicator_i(lk_i), .lock_indicator_o(lk_o), .lock_indicator_oe(lk_oe));
	serial_host u_serial_host (.r_pins(r_p), .m_pins(m_p), .a_pins(a_p), .select(sel));
	// ****************************************************************
	// Tasks
	// ****************************************************************
	task chk(input string what, input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task cyc(input int n);
		repeat (n) @(posedge core_clk);
	endtask : cyc
	task wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge core_clk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask : wr
	task rd(input logic [3:0] a, input logic [31:0] exp, input logic [31:0] msk);
		@(posedge core_clk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		@(negedge core_clk);
		chk($sformatf("reg %0h", a), reg_rdata & msk, exp);
	endtask : rd
	task pulse(input logic is_ref);
		@(posedge core_clk);
		if (is_ref) ref_in <= 1'b1;
		else osc_in <= 1'b1;
		cyc(5);
		ref_in <= 1'b0;
		osc_in <= 1'b0;
		cyc(5);
	endtask : pulse
	task results;
		if (num_errors == 0 && cmp_count > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : results
	// ****************************************************************
	// Stimulus
	// ****************************************************************
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	initial begin
		#200000;
		num_errors++;
		results;
	end
	initial begin
		{nrst, reg_wr, reg_rd, pe_n, mod_ch, gate, ref_in, osc_in} = '0;
		reg_addr  = '0;
		reg_wdata = '0;
		num_errors = 0;
		cmp_count  = 0;
		cyc(6);
		nrst <= 1'b1;
		rd(pll_ctl_pkg::OFF_WINDOW, 32'h0000_0004, '1);
		cyc(20);
		chk("lock_oe", lk_oe, 0);
		rd(pll_ctl_pkg::OFF_STATE, 32'h0000_0022, 32'h0000_0022);
		rd(pll_ctl_pkg::OFF_STATUS, 32'h0000_0001, '1);
		wr(pll_ctl_pkg::OFF_STATUS, 32'h0000_0001);
		wr(pll_ctl_pkg::OFF_MASK, 32'h0000_0004);
		u_serial_host.send(W, 1'b0, 1'b0);
		cyc(8);
		rd(pll_ctl_pkg::OFF_SECONDARY, 32'h0000_0000, '1);
		chk("irq", irq, 0);
		u_serial_host.strobe(1'b0);
		cyc(8);
		rd(pll_ctl_pkg::OFF_SECONDARY, W, '1);
		rd(pll_ctl_pkg::OFF_ACTIVE, W[18:0], '1);
		chk("irq", irq, 1);
		wr(pll_ctl_pkg::OFF_STATUS, 32'h0000_0004);
		rd(pll_ctl_pkg::OFF_STATUS, 32'h0000_0000, 32'h0000_0004);
		chk("irq", irq, 0);
		// Words shifted with the strobe high must not reach the primary register.
		u_serial_host.send(~W, 1'b0, 1'b1);
		u_serial_host.strobe(1'b1);
		cyc(8);
		rd(pll_ctl_pkg::OFF_SECONDARY, W, '1);
		u_serial_host.send(20'h0_00a5, 1'b1, 1'b1);
		cyc(8);
		rd(pll_ctl_pkg::OFF_AUX, 32'h0000_00a5, '1);
		rd(pll_ctl_pkg::OFF_STATUS, 32'h0000_0008, 32'h0000_0008);
		wr(pll_ctl_pkg::OFF_SECONDARY, 32'h0000_0000);
		rd(pll_ctl_pkg::OFF_SECONDARY, W, '1);
		rd(4'hf, 32'h0000_0000, '1);
		wr(pll_ctl_pkg::OFF_MASK, 32'h0000_0000);
		u_serial_host.direct(6'h2d, 9'h1a5, 4'h9);
		for (int k = 0; k < 2; k++) begin
			@(posedge core_clk);
			pe_n   <= k[0];
			mod_ch <= k[0];
			gate   <= ~k[0];
			cyc(6);
			rd(pll_ctl_pkg::OFF_STATE, {27'h0, ~k[0], k[0], k[0], 2'b01}, 32'h0000_001d);
		end
		rd(pll_ctl_pkg::OFF_ACTIVE, {13'h0, 6'h2d, 9'h1a5, 4'h9}, '1);
		u_serial_host.direct(6'h01, 9'h001, 4'h1);
		cyc(6);
		pulse(1'b1);
		chk("pumps", {pd, pu}, 2'b10);
		pulse(1'b0);
		chk("pumps", {pd, pu}, 2'b11);
		pulse(1'b0);
		chk("pumps", {pd, pu}, 2'b01);
		chk("nand", nand_n, 1);
		chk("lock_oe", lk_oe, 1);
		rd(pll_ctl_pkg::OFF_STATUS, 32'h0000_0002, 32'h0000_0002);
		// Prescaler on at 5/6: the main counter of one needs five oscillator rises.
		pulse(1'b1);
		chk("pumps", {pd, pu}, 2'b11);
		pe_n <= 1'b0;
		repeat (4) pulse(1'b0);
		chk("pumps", {pd, pu}, 2'b11);
		pulse(1'b0);
		chk("pumps", {pd, pu}, 2'b01);
		chk("mcs", mcs, 1);
		chk("mon", mon, 0);
		results;
	end
endmodule : pll_ctl_tb
